// [src/acr_params.svh]
// constants for the auxiliary control relay sequencer
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

`define ACR_OFF_WORD 8'h00
`define ACR_OFF_STROBE 8'h04
`define ACR_OFF_STATUS 8'h08
`define ACR_OFF_SHIFTQ 8'h0c
`define ACR_OFF_RELAY 8'h10

`define ACR_STAT_SHIFT_BIT 0
`define ACR_STAT_PULSE_BIT 1
`define ACR_STAT_ONEHOT_BIT 2

`define ACR_MODE_BWL_BIT 0
`define ACR_MODE_TXY_BIT 1
`define ACR_MODE_DLYA_BIT 2
`define ACR_MODE_DLYB_BIT 3
`define ACR_MODE_SIL_BIT 4
`define ACR_MODE_GA3_BIT 5
`define ACR_MODE_GA4_BIT 6
`define ACR_MODE_LIN_BIT 8
`define ACR_MODE_ILLUM_BIT 9
`define ACR_MODE_CTLA_BIT 10
`define ACR_MODE_CTLB_BIT 11

`define ACR_SHIFTQ_RESET 16'h0000
`define ACR_RELAY_RESET 8'h00

`define ACR_CLK_PERIOD_NS 50
`define ACR_STROBE_NS 2000
`define ACR_STROBE_CYC ((`ACR_STROBE_NS + `ACR_CLK_PERIOD_NS - 1) / `ACR_CLK_PERIOD_NS)
`define ACR_SHIFT_DIV 4
`define ACR_SH_OUTPUTS 6

`endif

// [src/acr_pkg.sv]
// types for the auxiliary control relay sequencer
package acr_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_STROBE} acr_state_e;
   typedef logic [15:0] acr_word_t;
endpackage : acr_pkg

// [src/acr_shift_stage.sv]
// one serial-in parallel-out shift register stage
`timescale 1ns/100ps
`default_nettype none
module acr_shift_stage #(
   parameter int WIDTH = 8
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic shiftEn,
   input wire logic serialIn,
   output logic [WIDTH-1:0] q,
   output logic serialOut
);
   logic [WIDTH-1:0] q_next;

   always_comb begin
      q_next = q;
      if (shiftEn) begin
         q_next = {q[WIDTH-2:0], serialIn};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= q_next;
      end
   end

   assign serialOut = q[WIDTH-1];
endmodule : acr_shift_stage
`default_nettype wire

// [src/acr_top.sv]
// auxiliary control relay sequencer: apb slave, serial shift chain, relay latch strobe
// What this block does
// - relay words of 16 bits shift serially into two cascaded 8-bit registers
// - coil lead outputs are the inverted register bits, selected lead low
// - a set relay keeps position until opposing data and a new pulse arrive
// - seven mode bits in the first register drive bandwidth, xy, delay, intensity, gains
// - four bits in the second register: linearity, illumination, two logic controls
// - linearity enable acts only on the two fastest sweep rates
// - enabled demultiplexer routes selects 0 to 5 to one of six sample-and-hold outputs; selects 6 and 7 drive none
// - relay combinations give four coupling modes and three attenuations per channel
//
// Decided for this implementation: the register addresses and register access over APB.
`include "acr_params.svh"
`timescale 1ns/100ps
`default_nettype none
module acr_top
   import acr_pkg::*;
#(
   parameter int STAGE_WIDTH = 8,
   parameter int NUM_STAGES = 2,
   parameter int SHIFT_DIV = `ACR_SHIFT_DIV,
   parameter int STROBE_CYC = `ACR_STROBE_CYC
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sweepFastRate,
   input wire logic demuxEnable,
   input wire logic [2:0] demuxSelect,
   output logic relayLatchPulse,
   output logic [15:0] coilLeadN,
   output logic [7:0] relayState,
   output logic [3:0] couplingMode,
   output logic [3:0] attenFactor,
   output logic bandwidthLimitEnable,
   output logic triggeredXyEnable,
   output logic sweepDelayComparatorEnableA,
   output logic sweepDelayComparatorEnableB,
   output logic slowIntensityLimit,
   output logic thirdChannelGainSelect,
   output logic fourthChannelGainSelect,
   output logic sweepLinearityActive,
   output logic scaleIllumSingleSequence,
   output logic measurementLogicCtrlA,
   output logic measurementLogicCtrlB,
   output logic [5:0] sampleHoldSelect
);
   localparam int CHAIN = STAGE_WIDTH * NUM_STAGES;

   acr_state_e state_reg, state_next;
   acr_word_t word_reg, word_next;
   logic [4:0] bitCnt_reg, bitCnt_next;
   logic [7:0] divCnt_reg, divCnt_next;
   logic [7:0] pulseCnt_reg, pulseCnt_next;
   logic [7:0] relay_reg, relay_next;
   logic [CHAIN-1:0] chainQ;
   logic [NUM_STAGES:0] serialLink;
   logic shiftEn;
   logic wordOneHot;
   logic apbAccess, apbDone, wrWord, wrStrobe;
   logic [31:0] rdData;
   logic rdErr;

   // serial shift chain, bit 15 of the word enters first
   assign serialLink[0] = word_reg[15];
   genvar g;
   generate
      for (g = 0; g < NUM_STAGES; g++) begin : gStage
         acr_shift_stage #(.WIDTH(STAGE_WIDTH)) uStage (
            .ref_clk(ref_clk),
            .reset(reset),
            .shiftEn(shiftEn),
            .serialIn(serialLink[g]),
            .q(chainQ[g*STAGE_WIDTH +: STAGE_WIDTH]),
            .serialOut(serialLink[g+1])
         );
      end
   endgenerate

   assign wordOneHot = $onehot(chainQ);
   assign apbAccess = psel && penable && !pready;
   assign apbDone = psel && penable && pready;
   assign wrWord = apbDone && pwrite && (paddr == `ACR_OFF_WORD);
   assign wrStrobe = apbDone && pwrite && (paddr == `ACR_OFF_STROBE) && pwdata[0];

   // sequencer: shift a word, or pulse the latch; busy requests are ignored
   always_comb begin
      state_next = state_reg;
      word_next = word_reg;
      bitCnt_next = bitCnt_reg;
      divCnt_next = divCnt_reg;
      pulseCnt_next = pulseCnt_reg;
      relay_next = relay_reg;
      shiftEn = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (wrWord) begin
               word_next = pwdata[15:0];
               bitCnt_next = 5'(CHAIN);
               divCnt_next = 8'(SHIFT_DIV - 1);
               state_next = ST_SHIFT;
            end else if (wrStrobe) begin
               pulseCnt_next = 8'(STROBE_CYC);
               state_next = ST_STROBE;
               if (wordOneHot) begin
                  for (int i = 0; i < CHAIN; i++) begin
                     if (chainQ[i]) begin
                        relay_next[i/2] = i[0];
                     end
                  end
               end
            end
         end
         ST_SHIFT: begin
            if (divCnt_reg == 8'h00) begin
               shiftEn = 1'b1;
               divCnt_next = 8'(SHIFT_DIV - 1);
               word_next = {word_reg[14:0], 1'b0};
               bitCnt_next = bitCnt_reg - 5'h01;
               if (bitCnt_reg == 5'h01) begin
                  state_next = ST_IDLE;
               end
            end else begin
               divCnt_next = divCnt_reg - 8'h01;
            end
         end
         ST_STROBE: begin
            pulseCnt_next = pulseCnt_reg - 8'h01;
            if (pulseCnt_reg == 8'h01) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_reg <= ST_IDLE;
         word_reg <= `ACR_SHIFTQ_RESET;
         bitCnt_reg <= 5'h00;
         divCnt_reg <= 8'h00;
         pulseCnt_reg <= 8'h00;
         relay_reg <= `ACR_RELAY_RESET;
      end else begin
         state_reg <= state_next;
         word_reg <= word_next;
         bitCnt_reg <= bitCnt_next;
         divCnt_reg <= divCnt_next;
         pulseCnt_reg <= pulseCnt_next;
         relay_reg <= relay_next;
      end
   end

   // apb read mux, answered one cycle into the access phase
   always_comb begin
      rdData = 32'h0000_0000;
      rdErr = 1'b0;
      case (paddr)
         `ACR_OFF_WORD: rdData = {16'h0000, word_reg};
         `ACR_OFF_STROBE: rdData = 32'h0000_0000;
         `ACR_OFF_STATUS: begin
            rdData[`ACR_STAT_SHIFT_BIT] = (state_reg == ST_SHIFT);
            rdData[`ACR_STAT_PULSE_BIT] = (state_reg == ST_STROBE);
            rdData[`ACR_STAT_ONEHOT_BIT] = wordOneHot;
         end
         `ACR_OFF_SHIFTQ: rdData = {16'h0000, chainQ};
         `ACR_OFF_RELAY: rdData = {16'h0000, attenFactor, couplingMode, relay_reg};
         default: rdErr = 1'b1;
      endcase
   end

   // output register bank: every port comes from a flip-flop
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         relayLatchPulse <= 1'b0;
         coilLeadN <= 16'hffff;
         relayState <= 8'h00;
         couplingMode <= 4'h0;
         attenFactor <= 4'h0;
         bandwidthLimitEnable <= 1'b0;
         triggeredXyEnable <= 1'b0;
         sweepDelayComparatorEnableA <= 1'b0;
         sweepDelayComparatorEnableB <= 1'b0;
         slowIntensityLimit <= 1'b0;
         thirdChannelGainSelect <= 1'b0;
         fourthChannelGainSelect <= 1'b0;
         sweepLinearityActive <= 1'b0;
         scaleIllumSingleSequence <= 1'b0;
         measurementLogicCtrlA <= 1'b0;
         measurementLogicCtrlB <= 1'b0;
         sampleHoldSelect <= 6'h00;
      end else begin
         pready <= apbAccess;
         prdata <= apbAccess && !pwrite ? rdData : 32'h0000_0000;
         pslverr <= apbAccess && rdErr;
         relayLatchPulse <= (state_next == ST_STROBE);
         coilLeadN <= ~chainQ;
         relayState <= relay_reg;
         for (int c = 0; c < 2; c++) begin
            couplingMode[2*c +: 2] <= {relay_reg[4*c+1], relay_reg[4*c]};
            attenFactor[2*c +: 2] <= relay_reg[4*c+3] ? 2'h2 : {1'b0, relay_reg[4*c+2]};
         end
         bandwidthLimitEnable <= chainQ[`ACR_MODE_BWL_BIT];
         triggeredXyEnable <= chainQ[`ACR_MODE_TXY_BIT];
         sweepDelayComparatorEnableA <= chainQ[`ACR_MODE_DLYA_BIT];
         sweepDelayComparatorEnableB <= chainQ[`ACR_MODE_DLYB_BIT];
         slowIntensityLimit <= chainQ[`ACR_MODE_SIL_BIT];
         thirdChannelGainSelect <= chainQ[`ACR_MODE_GA3_BIT];
         fourthChannelGainSelect <= chainQ[`ACR_MODE_GA4_BIT];
         sweepLinearityActive <= chainQ[`ACR_MODE_LIN_BIT] && sweepFastRate;
         scaleIllumSingleSequence <= chainQ[`ACR_MODE_ILLUM_BIT];
         measurementLogicCtrlA <= chainQ[`ACR_MODE_CTLA_BIT];
         measurementLogicCtrlB <= chainQ[`ACR_MODE_CTLB_BIT];
         sampleHoldSelect <= (demuxEnable && demuxSelect < 3'(`ACR_SH_OUTPUTS)) ?
                             (6'h01 << demuxSelect) : 6'h00;
      end
   end

   // helper counters watched only by the checks below
   logic [7:0] pulseLen;
   logic [5:0] shiftCount;
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pulseLen <= 8'h00;
         shiftCount <= 6'h00;
      end else begin
         pulseLen <= relayLatchPulse ? pulseLen + 8'h01 : 8'h00;
         shiftCount <= (state_reg == ST_SHIFT) ? shiftCount + 6'(shiftEn) : 6'h00;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   chk_pulse_length: assert property ($fell(relayLatchPulse) |-> pulseLen == 8'(STROBE_CYC))
      else $error("latch pulse length wrong");
   chk_pulse_not_shifting: assert property (relayLatchPulse |-> state_reg != ST_SHIFT)
      else $error("latch pulse during shifting");
   chk_shift_count: assert property (state_reg == ST_SHIFT && state_next == ST_IDLE |-> shiftCount == 6'(CHAIN - 1))
      else $error("word not fully shifted");
   chk_coil_inverts: assert property (##1 coilLeadN == ~$past(chainQ))
      else $error("coil leads not inverted register bits");
   chk_relay_hold: assert property ($changed(relay_reg) |-> $past(wrStrobe) && $past(wordOneHot))
      else $error("relay changed without strobe");
   chk_mode_bits: assert property (##1 bandwidthLimitEnable == $past(chainQ[0]) && fourthChannelGainSelect == $past(chainQ[6]))
      else $error("mode bits wrong");
   chk_second_bits: assert property (##1 measurementLogicCtrlB == $past(chainQ[11]) && scaleIllumSingleSequence == $past(chainQ[9]))
      else $error("second register bits wrong");
   chk_linearity_gate: assert property (!sweepFastRate |=> !sweepLinearityActive)
      else $error("linearity active on slow sweep");
   chk_demux_route: assert property (demuxEnable && demuxSelect == 3'h5 |=> sampleHoldSelect == 6'h20 ##0 $onehot(sampleHoldSelect))
      else $error("demux route wrong");
   chk_atten_decode: assert property (attenFactor[1:0] != 2'h3 && attenFactor[3:2] != 2'h3)
      else $error("illegal attenuation code");
endmodule : acr_top
`default_nettype wire

// [test/acr_cpu_model.sv]
// apb master standing in for the system processor
`timescale 1ns/100ps
`default_nettype none
module acr_cpu_model (
   input wire logic ref_clk,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   output logic [7:0] paddr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] pwdata
);
   initial begin
      paddr = 8'h00;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = 32'h0;
   end

   // call just after a rising edge; returns one idle edge after the edge that saw pready
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge keeps the next request from rewriting psel in this time step
      @(posedge ref_clk);
   endtask : xfer
endmodule : acr_cpu_model
`default_nettype wire

// [test/tb_aux_control_relay_sequencer.sv]
// self-checking bench for the auxiliary control relay sequencer
`include "acr_params.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module tb_aux_control_relay_sequencer;
   import acr_pkg::*;
   logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, pulse, fast, dmxEn;
   logic [7:0] paddr, relayState;
   logic [31:0] pwdata, prdata, rdv;
   logic [2:0] dmxSel;
   logic [15:0] coilLeadN;
   logic [3:0] couplingMode, attenFactor;
   logic [10:0] modes;
   logic [5:0] shSel;
   int num_errors = 0;
   int checks_done = 0;
   int pulseCnt = 0;
   logic err;

   acr_cpu_model cpu (.ref_clk(ref_clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata));
   acr_top #(.SHIFT_DIV(1), .STROBE_CYC(4)) dut (.ref_clk(ref_clk), .reset(reset),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sweepFastRate(fast),
      .demuxEnable(dmxEn), .demuxSelect(dmxSel), .relayLatchPulse(pulse), .coilLeadN(coilLeadN),
      .relayState(relayState), .couplingMode(couplingMode), .attenFactor(attenFactor),
      .bandwidthLimitEnable(modes[0]), .triggeredXyEnable(modes[1]),
      .sweepDelayComparatorEnableA(modes[2]), .sweepDelayComparatorEnableB(modes[3]),
      .slowIntensityLimit(modes[4]), .thirdChannelGainSelect(modes[5]),
      .fourthChannelGainSelect(modes[6]), .sweepLinearityActive(modes[7]),
      .scaleIllumSingleSequence(modes[8]), .measurementLogicCtrlA(modes[9]),
      .measurementLogicCtrlB(modes[10]), .sampleHoldSelect(shSel));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) if (pulse === 1'b1) pulseCnt++;

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      cpu.xfer(1'b1, a, d, rdv, err);
   endtask : wr

   task automatic waitIdle();
      do begin
         cpu.xfer(1'b0, `ACR_OFF_STATUS, 32'h0, rdv, err);
      end while (rdv[1:0] !== 2'b00);
   endtask : waitIdle

   task automatic load(input logic [15:0] w);
      wr(`ACR_OFF_WORD, {16'h0, w});
      waitIdle();
   endtask : load

   task automatic strobe();
      pulseCnt = 0;
      wr(`ACR_OFF_STROBE, 32'h1);
      waitIdle();
   endtask : strobe

   task automatic t_relays();
      logic [15:0] w;
      logic [7:0] exp;
      exp = 8'h00;
      `CHK(coilLeadN, 16'hffff)
      for (int r = 0; r < 8; r++) begin
         w = 16'h1 << (2 * r + 1);
         load(w);
         `CHK(coilLeadN, ~w)
         cpu.xfer(1'b0, `ACR_OFF_SHIFTQ, 32'h0, rdv, err);
         `CHK(rdv[15:0], w)
         strobe();
         exp[r] = 1'b1;
         `CHK(pulseCnt, 4)
         `CHK(relayState, exp)
      end
      `CHK({couplingMode, attenFactor}, 8'hfa)
   endtask : t_relays

   task automatic t_hold();
      load(16'h0001);
      `CHK(relayState, 8'hff)
      strobe();
      `CHK(relayState, 8'hfe)
      `CHK(couplingMode, 4'he)
      load(16'h0003);
      cpu.xfer(1'b0, `ACR_OFF_STATUS, 32'h0, rdv, err);
      `CHK(rdv[2], 1'b0)
      strobe();
      `CHK(relayState, 8'hfe)
      wr(`ACR_OFF_WORD, 32'h0004);
      pulseCnt = 0;
      wr(`ACR_OFF_STROBE, 32'h1);
      waitIdle();
      `CHK(pulseCnt, 0)
      `CHK(relayState, 8'hfe)
      cpu.xfer(1'b0, 8'h20, 32'h0, rdv, err);
      `CHK({err, rdv}, 33'h100000000)
   endtask : t_hold

   // overload on channel 0: coupling leaves the terminated position, all eight relays are rerun
   task automatic t_rerun();
      logic [15:0] w;
      for (int r = 0; r < 8; r++) begin
         w = (r < 2) ? (16'h1 << (2 * r)) : (16'h1 << (2 * r + 1));
         load(w);
         strobe();
         `CHK(pulseCnt, 4)
      end
      `CHK(relayState, 8'hfc)
      `CHK({couplingMode, attenFactor}, 8'hca)
   endtask : t_rerun

   task automatic t_modes();
      int b;
      for (int i = 0; i < 11; i++) begin
         b = (i < 7) ? i : i + 1;
         load(16'h1 << b);
         `CHK(modes, 11'h1 << i)
      end
      fast <= 1'b0;
      load(16'h0100);
      `CHK(modes, 11'h000)
   endtask : t_modes

   task automatic t_demux();
      for (int s = 0; s < 8; s++) begin
         dmxEn <= 1'b1;
         dmxSel <= 3'(s);
         repeat (3) @(posedge ref_clk);
         `CHK(shSel, (s < 6) ? (6'h1 << s) : 6'h00)
      end
      dmxEn <= 1'b0;
      dmxSel <= 3'h2;
      repeat (3) @(posedge ref_clk);
      `CHK(shSel, 6'h00)
   endtask : t_demux

   task automatic print_verdict();
      if (num_errors == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict

   initial begin
      reset = 1'b1;
      fast = 1'b1;
      dmxEn = 1'b0;
      dmxSel = 3'h0;
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      t_relays();
      t_hold();
      t_rerun();
      t_modes();
      t_demux();
      print_verdict();
   end

   initial begin
      #(50 * 40000);
      num_errors++;
      print_verdict();
   end
endmodule : tb_aux_control_relay_sequencer
`default_nettype wire
